// ---- core/tcpc_defines.svh ----
// Constants for the Type-C configuration channel port controller
// --------------------------------------------------------------
// Behaviour
// - Role strap is sampled only at reset and held until next reset.
// - Strap high: source only, pull-ups on both CC pins always.
// - Strap low: sink only, pull-downs on both CC pins always.
// - Strap floating: dual role, toggling source and sink until attach.
// - Sink attach needs debounced CC and bus-power detection.
// - Source advertises default current when level input is low.
// - Source advertises 1.5 A on mid level, 3 A on high.
// - Sink reports detected level on two status outputs per table.
// - Bus power decides sink attach, detach and dual-role resolution.
// - Orientation output low for CC1, released high for CC2.
// - VCONN to unused pin only in attached source with Ra there.
// - VCONN withdrawn on detach.
// - Start in unattached sink state after power-up, then follow role.
// - Unattached, attach-wait, attached states per role family.
// - Attach shown on attach flag as source, status outputs as sink.
// - Leave attached on unplug, or bus-power loss when sink.
// - CC level changes debounced 168 ms.
// - Bus-power sense debounced 2 ms.
// - Dual-role toggle period 75 ms, source for 30 percent.
// --------------------------------------------------------------
`ifndef TCPC_DEFINES_SVH
`define TCPC_DEFINES_SVH

`define TCPC_CLK_MHZ 100
`define TCPC_CC_DB_MS 168
`define TCPC_VBUS_DB_MS 2
`define TCPC_DRP_PERIOD_MS 75
`define TCPC_DRP_SRC_PCT 30
`define TCPC_CC_DB_CYC (`TCPC_CC_DB_MS * 1000 * `TCPC_CLK_MHZ)
`define TCPC_VBUS_DB_CYC (`TCPC_VBUS_DB_MS * 1000 * `TCPC_CLK_MHZ)
`define TCPC_DRP_PERIOD_CYC (`TCPC_DRP_PERIOD_MS * 1000 * `TCPC_CLK_MHZ)
`define TCPC_DRP_SRC_CYC (`TCPC_DRP_PERIOD_CYC * `TCPC_DRP_SRC_PCT / 100)

// Tri-level encodings for strap and advertisement level
`define TCPC_TRI_LOW 2'h0
`define TCPC_TRI_MID 2'h1
`define TCPC_TRI_HIGH 2'h2

// Detected CC level encodings
`define TCPC_CC_OPEN 2'h0
`define TCPC_CC_RA 2'h1
`define TCPC_CC_RD 2'h2

`endif

// ---- core/tcpc_pkg.sv ----
// Types for the Type-C configuration channel port controller
package tcpc_pkg;
  typedef enum logic [1:0] {
    TCPC_ROLE_SRC,
    TCPC_ROLE_SNK,
    TCPC_ROLE_DRP
  } tcpc_role_t;

  typedef enum logic [2:0] {
    TCPC_UNATT_SNK,
    TCPC_WAIT_SNK,
    TCPC_ATT_SNK,
    TCPC_UNATT_SRC,
    TCPC_WAIT_SRC,
    TCPC_ATT_SRC
  } tcpc_state_t;
endpackage

// ---- core/tcpc_port_ctrl.sv ----
// Type-C configuration channel port controller, single-clock logic
`timescale 1ns/10ps
`include "tcpc_defines.svh"

module tcpc_port_ctrl #(
  parameter int CC_DB_CYC = `TCPC_CC_DB_CYC,
  parameter int VBUS_DB_CYC = `TCPC_VBUS_DB_CYC,
  parameter int DRP_PERIOD_CYC = `TCPC_DRP_PERIOD_CYC,
  parameter int DRP_SRC_CYC = `TCPC_DRP_SRC_CYC
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Straps
  input wire logic [1:0] role_strap_i,
  input wire logic [1:0] adv_level_i,
  // Comparator results per CC pin
  input wire logic [1:0] cc1_level_i,
  input wire logic [1:0] cc2_level_i,
  input wire logic [1:0] cc_sink_level_i,
  input wire logic bus_power_sense_i,
  // Termination control
  output logic cc_pullup_o,
  output logic cc_pulldown_o,
  output logic [1:0] adv_current_o,
  output logic vconn_cc1_o,
  output logic vconn_cc2_o,
  // Open-drain status pins, enable high means pulled low; state_o is a plain state code
  output logic dir_oe_o,
  output logic source_attach_flag_oe_o,
  output logic sink_level_status_a_oe_o,
  output logic sink_level_status_b_oe_o,
  output logic [2:0] state_o
);

  localparam int CNT_W = 32;

  // --------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------
  // Counters are 32 bits wide, so every count must be positive
  if (CC_DB_CYC < 1) begin
    $error("tcpc_port_ctrl: CC debounce count must be positive");
  end
  if (VBUS_DB_CYC < 1) begin
    $error("tcpc_port_ctrl: bus-power debounce count must be positive");
  end
  if (DRP_PERIOD_CYC < 2) begin
    $error("tcpc_port_ctrl: toggle period too short");
  end
  if (DRP_SRC_CYC < 1 || DRP_SRC_CYC >= DRP_PERIOD_CYC) begin
    $error("tcpc_port_ctrl: source share must lie inside the period");
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Saturating timer step
  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c);
    step = (c == {CNT_W{1'b1}}) ? c : c + 32'h00000001;
  endfunction

  // Pull-ups stand in every source-family state
  function automatic logic src_family(input tcpc_pkg::tcpc_state_t s);
    case (s)
      tcpc_pkg::TCPC_UNATT_SRC: src_family = 1'b1;
      tcpc_pkg::TCPC_WAIT_SRC: src_family = 1'b1;
      tcpc_pkg::TCPC_ATT_SRC: src_family = 1'b1;
      default: src_family = 1'b0;
    endcase
  endfunction

  // A partner has been seen, so the orientation output means something
  function automatic logic src_engaged(input tcpc_pkg::tcpc_state_t s);
    case (s)
      tcpc_pkg::TCPC_WAIT_SRC: src_engaged = 1'b1;
      tcpc_pkg::TCPC_ATT_SRC: src_engaged = 1'b1;
      default: src_engaged = 1'b0;
    endcase
  endfunction

  function automatic logic snk_engaged(input tcpc_pkg::tcpc_state_t s);
    case (s)
      tcpc_pkg::TCPC_WAIT_SNK: snk_engaged = 1'b1;
      tcpc_pkg::TCPC_ATT_SNK: snk_engaged = 1'b1;
      default: snk_engaged = 1'b0;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Role strap
  // --------------------------------------------------------------
  // Strap caught on the first enabled edge after reset release only
  logic strap_done;
  tcpc_pkg::tcpc_role_t strap_role;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_done <= 1'b0;
      strap_role <= tcpc_pkg::TCPC_ROLE_SNK;
    end else if (ce_i && !strap_done) begin
      strap_done <= 1'b1;
      case (role_strap_i)
        `TCPC_TRI_HIGH: strap_role <= tcpc_pkg::TCPC_ROLE_SRC;
        `TCPC_TRI_LOW: strap_role <= tcpc_pkg::TCPC_ROLE_SNK;
        default: strap_role <= tcpc_pkg::TCPC_ROLE_DRP;
      endcase
    end
  end

  // --------------------------------------------------------------
  // CC debouncer
  // --------------------------------------------------------------
  logic [1:0] cc1_seen;
  logic [1:0] cc2_seen;
  logic [1:0] snk_seen;
  logic [CNT_W-1:0] cc_cnt;
  logic [1:0] cc1_stable;
  logic [1:0] cc2_stable;
  // Shared by both attach-wait states, so the sink pin restarts it too
  logic cc_settled;
  assign cc_settled = cc_cnt >= CNT_W'(CC_DB_CYC);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc1_seen <= `TCPC_CC_OPEN;
      cc2_seen <= `TCPC_CC_OPEN;
      snk_seen <= `TCPC_CC_OPEN;
      cc_cnt <= 32'h00000000;
      cc1_stable <= `TCPC_CC_OPEN;
      cc2_stable <= `TCPC_CC_OPEN;
    end else if (ce_i) begin
      cc1_seen <= cc1_level_i;
      cc2_seen <= cc2_level_i;
      snk_seen <= cc_sink_level_i;
      if (cc1_level_i != cc1_seen || cc2_level_i != cc2_seen ||
          cc_sink_level_i != snk_seen) begin
        cc_cnt <= 32'h00000000;
      end else begin
        cc_cnt <= step(cc_cnt);
      end
      if (cc_settled) begin
        cc1_stable <= cc1_seen;
        cc2_stable <= cc2_seen;
      end
    end
  end

  // --------------------------------------------------------------
  // Bus-power debouncer
  // --------------------------------------------------------------
  logic vbus_seen;
  logic [CNT_W-1:0] vbus_cnt;
  logic vbus_ok;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vbus_seen <= 1'b0;
      vbus_cnt <= 32'h00000000;
      vbus_ok <= 1'b0;
    end else if (ce_i) begin
      vbus_seen <= bus_power_sense_i;
      if (bus_power_sense_i != vbus_seen) begin
        vbus_cnt <= 32'h00000000;
      end else begin
        vbus_cnt <= step(vbus_cnt);
      end
      if (!vbus_seen) begin
        vbus_ok <= 1'b0; // Loss acts at once so detach is prompt
      end else if (vbus_cnt >= CNT_W'(VBUS_DB_CYC)) begin
        vbus_ok <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // Dual-role toggle timer
  // --------------------------------------------------------------
  logic [CNT_W-1:0] drp_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drp_cnt <= 32'h00000000;
    end else if (ce_i) begin
      if (drp_cnt >= CNT_W'(DRP_PERIOD_CYC - 1)) begin
        drp_cnt <= 32'h00000000;
      end else begin
        drp_cnt <= drp_cnt + 32'h00000001;
      end
    end
  end
  logic drp_src_time;
  assign drp_src_time = drp_cnt < CNT_W'(DRP_SRC_CYC);

  // --------------------------------------------------------------
  // Attach state machine
  // --------------------------------------------------------------
  logic src_seen_rd;
  logic snk_seen_rp;
  logic src_gone;
  assign src_seen_rd = (cc1_stable == `TCPC_CC_RD) != (cc2_stable == `TCPC_CC_RD);
  assign snk_seen_rp = (cc_sink_level_i != `TCPC_CC_OPEN);
  assign src_gone = (cc1_stable != `TCPC_CC_RD) && (cc2_stable != `TCPC_CC_RD);

  tcpc_pkg::tcpc_state_t state;
  tcpc_pkg::tcpc_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      tcpc_pkg::TCPC_UNATT_SNK: begin
        if (!strap_done) begin
          next_state = state;
        end else if (strap_role == tcpc_pkg::TCPC_ROLE_SRC) begin
          next_state = tcpc_pkg::TCPC_UNATT_SRC;
        end else if (snk_seen_rp) begin
          next_state = tcpc_pkg::TCPC_WAIT_SNK;
        end else if (strap_role == tcpc_pkg::TCPC_ROLE_DRP && drp_src_time) begin
          next_state = tcpc_pkg::TCPC_UNATT_SRC;
        end
      end
      tcpc_pkg::TCPC_WAIT_SNK: begin
        if (!snk_seen_rp) begin
          next_state = tcpc_pkg::TCPC_UNATT_SNK;
        end else if (cc_settled && vbus_ok) begin
          next_state = tcpc_pkg::TCPC_ATT_SNK;
        end
      end
      tcpc_pkg::TCPC_ATT_SNK: begin
        if (!vbus_seen || !snk_seen_rp) begin
          next_state = tcpc_pkg::TCPC_UNATT_SNK;
        end
      end
      tcpc_pkg::TCPC_UNATT_SRC: begin
        if (src_seen_rd) begin
          next_state = tcpc_pkg::TCPC_WAIT_SRC;
        end else if (strap_role == tcpc_pkg::TCPC_ROLE_DRP && !drp_src_time) begin
          next_state = tcpc_pkg::TCPC_UNATT_SNK;
        end
      end
      tcpc_pkg::TCPC_WAIT_SRC: begin
        if (!src_seen_rd) begin
          next_state = tcpc_pkg::TCPC_UNATT_SRC;
        end else if (cc_settled) begin
          next_state = tcpc_pkg::TCPC_ATT_SRC;
        end
      end
      tcpc_pkg::TCPC_ATT_SRC: begin
        if (src_gone) begin
          next_state = tcpc_pkg::TCPC_UNATT_SRC;
        end
      end
      default: next_state = tcpc_pkg::TCPC_UNATT_SNK;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= tcpc_pkg::TCPC_UNATT_SNK;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  logic is_src_next;
  assign is_src_next = src_family(next_state);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc_pullup_o <= 1'b0;
      cc_pulldown_o <= 1'b1;
      adv_current_o <= `TCPC_TRI_LOW;
    end else if (ce_i) begin
      cc_pullup_o <= is_src_next;
      cc_pulldown_o <= !is_src_next;
      case (adv_level_i)
        `TCPC_TRI_MID: adv_current_o <= `TCPC_TRI_MID;
        `TCPC_TRI_HIGH: adv_current_o <= `TCPC_TRI_HIGH;
        default: adv_current_o <= `TCPC_TRI_LOW;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vconn_cc1_o <= 1'b0;
      vconn_cc2_o <= 1'b0;
    end else if (ce_i) begin
      // Removal follows the detach transition at once
      vconn_cc1_o <= next_state == tcpc_pkg::TCPC_ATT_SRC &&
                     cc1_stable == `TCPC_CC_RA && cc2_stable == `TCPC_CC_RD;
      vconn_cc2_o <= next_state == tcpc_pkg::TCPC_ATT_SRC &&
                     cc2_stable == `TCPC_CC_RA && cc1_stable == `TCPC_CC_RD;
    end
  end

  // --------------------------------------------------------------
  // Status pins
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (src_engaged(next_state)) begin
        dir_oe_o <= cc1_stable == `TCPC_CC_RD;
      end else if (snk_engaged(next_state)) begin
        dir_oe_o <= cc1_level_i != `TCPC_CC_OPEN;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_o <= 3'h0;
    end else if (ce_i) begin
      state_o <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      source_attach_flag_oe_o <= 1'b0;
    end else if (ce_i) begin
      source_attach_flag_oe_o <= next_state == tcpc_pkg::TCPC_ATT_SRC;
    end
  end

  // Level pins double as the sink's attach sign; unattached leaves both released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sink_level_status_a_oe_o <= 1'b0;
      sink_level_status_b_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (next_state == tcpc_pkg::TCPC_ATT_SNK) begin
        case (cc_sink_level_i)
          `TCPC_TRI_MID: begin
            sink_level_status_a_oe_o <= 1'b1;
            sink_level_status_b_oe_o <= 1'b0;
          end
          `TCPC_TRI_HIGH: begin
            sink_level_status_a_oe_o <= 1'b1;
            sink_level_status_b_oe_o <= 1'b1;
          end
          default: begin
            sink_level_status_a_oe_o <= 1'b0;
            sink_level_status_b_oe_o <= 1'b1;
          end
        endcase
      end else begin
        sink_level_status_a_oe_o <= 1'b0;
        sink_level_status_b_oe_o <= 1'b0;
      end
    end
  end

endmodule

// ---- tb/tcpc_port_ctrl_sva.sv ----
// Concurrent checks on the port controller pins
`timescale 1ns/10ps
`include "tcpc_defines.svh"

module tcpc_port_ctrl_sva #(
  parameter int CC_DB_CYC = 20,
  parameter int VBUS_DB_CYC = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched inputs
  input wire logic [1:0] cc1_level_i,
  input wire logic [1:0] cc2_level_i,
  input wire logic [1:0] cc_sink_level_i,
  input wire logic bus_power_sense_i,
  // Watched outputs
  input wire logic cc_pullup_o,
  input wire logic cc_pulldown_o,
  input wire logic vconn_cc1_o,
  input wire logic vconn_cc2_o,
  input wire logic dir_oe_o,
  input wire logic source_attach_flag_oe_o,
  input wire logic [2:0] state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Stable-run counters, margin of two for edge alignment
  // ----------------------------------------
  logic [3:0] last_src;
  logic [1:0] last_snk;
  logic [7:0] src_run;
  logic [7:0] snk_run;
  logic [7:0] vb_run;
  always_ff @(posedge clk_i) begin
    last_src <= {cc1_level_i, cc2_level_i};
    if (rst_i || {cc1_level_i, cc2_level_i} != last_src) src_run <= 8'h00;
    else if (src_run != 8'hFF) src_run <= src_run + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    last_snk <= cc_sink_level_i;
    if (rst_i || cc_sink_level_i != last_snk) snk_run <= 8'h00;
    else if (snk_run != 8'hFF) snk_run <= snk_run + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !bus_power_sense_i) vb_run <= 8'h00;
    else if (vb_run != 8'hFF) vb_run <= vb_run + 8'h01;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_reset_state: assert property ($fell(rst_i) |-> state_o == 3'h0 && cc_pulldown_o)
    else $error("state after reset wrong");
  chk_pull_excl: assert property (cc_pullup_o != cc_pulldown_o)
    else $error("pull-up and pull-down not exclusive");
  chk_vconn_att: assert property ((vconn_cc1_o || vconn_cc2_o) |-> state_o == 3'h5)
    else $error("vconn outside attached source");
  chk_vconn_ra: assert property ($rose(vconn_cc2_o) |-> $past(cc2_level_i) == `TCPC_CC_RA)
    else $error("vconn without cable termination");
  chk_flag_src: assert property (source_attach_flag_oe_o == (state_o == 3'h5))
    else $error("attach flag mismatch");
  chk_snk_debounce: assert property ($rose(state_o == 3'h2) |->
    vb_run >= VBUS_DB_CYC - 2 && snk_run >= CC_DB_CYC - 2)
    else $error("sink attached too early");
  chk_src_debounce: assert property ($rose(state_o == 3'h5) |-> src_run >= CC_DB_CYC - 2)
    else $error("source attached too early");
  chk_unplug_snk: assert property (state_o == 3'h2 && $fell(bus_power_sense_i) |->
    ##2 state_o == 3'h0)
    else $error("sink kept attach without bus power");
  chk_dir_cc1: assert property ($rose(source_attach_flag_oe_o) |->
    dir_oe_o == ($past(cc1_level_i) == `TCPC_CC_RD))
    else $error("orientation output wrong");
  chk_vconn_cc1_ra: assert property ($rose(vconn_cc1_o) |->
    $past(cc1_level_i) == `TCPC_CC_RA)
    else $error("vconn on first pin without cable termination");
endmodule

bind tcpc_port_ctrl tcpc_port_ctrl_sva #(.CC_DB_CYC(CC_DB_CYC), .VBUS_DB_CYC(VBUS_DB_CYC)) i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cc1_level_i(cc1_level_i), .cc2_level_i(cc2_level_i),
  .cc_sink_level_i(cc_sink_level_i), .bus_power_sense_i(bus_power_sense_i),
  .cc_pullup_o(cc_pullup_o), .cc_pulldown_o(cc_pulldown_o), .vconn_cc1_o(vconn_cc1_o),
  .vconn_cc2_o(vconn_cc2_o), .dir_oe_o(dir_oe_o),
  .source_attach_flag_oe_o(source_attach_flag_oe_o), .state_o(state_o));

// ---- tb/tcpc_far_port.sv ----
// Remote Type-C port seen over the CC wires
`timescale 1ns/10ps
`include "tcpc_defines.svh"

module tcpc_far_port (
  // Control: role 0 none, 1 sink with active cable, 2 source, 3 sink with plain cable
  input wire logic [1:0] far_role_i,
  input wire logic flip_i,
  input wire logic [1:0] rp_i,
  input wire logic vbus_i,
  // Levels seen by the controller
  output logic [1:0] cc1_level_o,
  output logic [1:0] cc2_level_o,
  output logic [1:0] cc_sink_level_o,
  output logic bus_power_o
);
  // Cable puts Ra on the pin opposite the sink's Rd
  always_comb begin
    cc1_level_o = `TCPC_CC_OPEN;
    cc2_level_o = `TCPC_CC_OPEN;
    if (far_role_i == 2'h1 || far_role_i == 2'h3) begin
      cc1_level_o = flip_i ? `TCPC_CC_RA : `TCPC_CC_RD;
      cc2_level_o = flip_i ? `TCPC_CC_RD : `TCPC_CC_RA;
    end
    // Plain cable: no Ra, so the pin opposite Rd stays open
    if (far_role_i == 2'h3) begin
      if (flip_i) cc1_level_o = `TCPC_CC_OPEN;
      else cc2_level_o = `TCPC_CC_OPEN;
    end
    cc_sink_level_o = (far_role_i == 2'h2) ? rp_i : 2'h0;
    bus_power_o = (far_role_i == 2'h2) && vbus_i;
  end
endmodule

// ---- tb/tb_tcpc_port_ctrl.sv ----
// Self-checking bench for the port controller
`timescale 1ns/10ps

module tb_tcpc_port_ctrl;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] role_strap_i = 2'h0;
  logic [1:0] adv_level_i = 2'h0;
  logic [1:0] far_role = 2'h0;
  logic flip = 1'b0;
  logic [1:0] rp = 2'h0;
  logic vbus = 1'b0;
  logic [1:0] cc1, cc2, snk_lvl;
  logic bus_pwr, cc_pullup_o, cc_pulldown_o, vconn_cc1_o, vconn_cc2_o, dir_oe_o;
  logic source_attach_flag_oe_o, sink_level_status_a_oe_o, sink_level_status_b_oe_o;
  logic [1:0] adv_current_o;
  logic [2:0] state_o;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  // Shortened counts keep the run brief
  tcpc_port_ctrl #(.CC_DB_CYC(20), .VBUS_DB_CYC(5), .DRP_PERIOD_CYC(100), .DRP_SRC_CYC(30))
    i_tcpc_port_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .role_strap_i(role_strap_i),
    .adv_level_i(adv_level_i), .cc1_level_i(cc1), .cc2_level_i(cc2), .cc_sink_level_i(snk_lvl),
    .bus_power_sense_i(bus_pwr), .cc_pullup_o(cc_pullup_o), .cc_pulldown_o(cc_pulldown_o),
    .adv_current_o(adv_current_o), .vconn_cc1_o(vconn_cc1_o), .vconn_cc2_o(vconn_cc2_o),
    .dir_oe_o(dir_oe_o), .source_attach_flag_oe_o(source_attach_flag_oe_o),
    .sink_level_status_a_oe_o(sink_level_status_a_oe_o),
    .sink_level_status_b_oe_o(sink_level_status_b_oe_o), .state_o(state_o));
  tcpc_far_port i_tcpc_far_port (.far_role_i(far_role), .flip_i(flip), .rp_i(rp), .vbus_i(vbus),
    .cc1_level_o(cc1), .cc2_level_o(cc2), .cc_sink_level_o(snk_lvl), .bus_power_o(bus_pwr));
  initial forever #5 clk_i = ~clk_i;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] strap);
    rst_i = 1'b1;
    role_strap_i = strap;
    repeat (8) @(negedge clk_i);
    check("reset state", 8'h00, {5'h00, state_o});
    check("reset pull-down", 8'h01, {7'h00, cc_pulldown_o});
    rst_i = 1'b0;
  endtask
  task automatic wait_state(input logic [2:0] s);
    int k;
    k = 0;
    while (state_o !== s && k < 200) begin
      @(negedge clk_i);
      k++;
    end
    check("state", {5'h00, s}, {5'h00, state_o});
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  initial begin
    do_reset(2'h2);
    for (int i = 0; i < 4; i++) begin
      flip = i[0];
      adv_level_i = i[1:0];
      far_role = (i == 3) ? 2'h3 : 2'h1;
      wait_state(3'h5);
      check("pull-up", 8'h01, {7'h00, cc_pullup_o});
      check("attach flag", 8'h01, {7'h00, source_attach_flag_oe_o});
      check("orientation", {7'h00, !flip}, {7'h00, dir_oe_o});
      check("vconn", (i == 3) ? 8'h00 : {6'h00, flip, !flip},
        {6'h00, vconn_cc1_o, vconn_cc2_o});
      check("advertised", (i == 3) ? 8'h00 : i[7:0], {6'h00, adv_current_o});
      far_role = 2'h0;
      wait_state(3'h3);
      check("vconn off", 8'h00, {6'h00, vconn_cc1_o, vconn_cc2_o});
    end
    role_strap_i = 2'h0;
    repeat (10) @(negedge clk_i);
    check("role held", 8'h01, {7'h00, cc_pullup_o});
    do_reset(2'h0);
    for (int i = 1; i < 4; i++) begin
      far_role = 2'h2;
      rp = i[1:0];
      vbus = 1'b0;
      repeat (40) @(negedge clk_i);
      check("no power wait", 8'h01, {5'h00, state_o});
      vbus = 1'b1;
      wait_state(3'h2);
      check("pull-down", 8'h01, {7'h00, cc_pulldown_o});
      check("level status", (i == 1) ? 8'h02 : (i == 2) ? 8'h03 : 8'h01,
        {6'h00, sink_level_status_a_oe_o, sink_level_status_b_oe_o});
      vbus = 1'b0;
      @(negedge clk_i);
      @(negedge clk_i);
      check("power loss", 8'h00, {5'h00, state_o});
      far_role = 2'h0;
      repeat (5) @(negedge clk_i);
    end
    far_role = 2'h2;
    rp = 2'h1;
    vbus = 1'b1;
    repeat (15) @(negedge clk_i);
    check("cc debounce", 8'h01, {5'h00, state_o});
    wait_state(3'h2);
    far_role = 2'h0;
    vbus = 1'b0;
    do_reset(2'h1);
    repeat (10) @(negedge clk_i);
    n = 0;
    repeat (100) begin
      @(negedge clk_i);
      if (cc_pullup_o === 1'b1) n++;
    end
    check("source share", 8'd30, n[7:0]);
    conclude();
  end
endmodule
